// ### rtl/sefe_front_end.sv
// Purpose: Serial front end of a 4096 byte SPI EEPROM with its array
// Assumes: sck, cs_n, si, hold_n, wp_n are pins; sck well below clk / 4
// Notes: Status nonvolatile bits are flops cleared by sys_rst
//
// Functional notes
// - Eight-bit command register loads the first byte after select.
// - Serial input sampled on each rising serial clock edge while selected and not paused.
// - First bit captured on first rising edge after select falls.
// - All bytes shift most significant bit first in both directions.
// - With protect enable set, status writes need write-protect pin high.
// - Write-protect input can block status register writes.
// - While paused, inputs other than select are ignored, state frozen.
// - After pause release, transaction resumes at the same bit.
// - Device responds only while its select is asserted.
// - Write cycle starts on select rise after valid write, lasting 5 ms.
// - Accepts serial modes 0,0 and 1,1, sampling on rising edges.
// - Array holds 4096 bytes of eight bits, byte addressed.
// - Command codes 06,04,05,01,03,02 for latch, status and array ops.
// - Write latch set by command; writes proceed only while set.
// - Status bit0 busy, bit1 write latch, bit7 protect enable.
// - Serial output changes after falling serial clock edges.
`timescale 1ns/1ps
module sefe_front_end
    import sefe_pkg::*;
#(
    parameter int WRITE_CYCLES = SEFE_WRITE_CYCLES,
    parameter int MEM_BYTES = SEFE_MEM_BYTES,
    parameter int PAGE_BYTES = SEFE_PAGE_BYTES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic so_out,
    output logic so_oe,
    output logic write_busy_flag,
    output logic write_latch_flag,
    output logic [7:0] status_out
);
    localparam int AW = $clog2(MEM_BYTES);
    localparam int PW = $clog2(PAGE_BYTES);
    localparam int CW = $clog2(WRITE_CYCLES + 1);

    sefe_pins_t pins;
    sefe_pins_t pins_sync;
    logic sck_d_reg;
    logic rise;
    logic fall;
    logic selected;
    logic active;

    logic [7:0] mem [MEM_BYTES];
    logic [7:0] page_buf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] page_dirty_reg;

    sefe_state_t state_reg;
    logic [7:0] shift_reg;
    logic [2:0] bit_cnt_reg;
    logic [1:0] addr_bytes_reg;
    logic [15:0] addr_reg;
    logic [7:0] out_reg;
    logic so_reg;
    logic write_pend_reg;
    logic status_pend_reg;
    logic latch_pend_set_reg;
    logic latch_pend_clr_reg;
    logic [2:0] status_new_reg;
    logic [2:0] nv_reg;
    logic latch_reg;
    logic busy_reg;
    logic [CW-1:0] busy_cnt_reg;
    logic [AW-1:0] commit_base_reg;
    logic [7:0] shift_next;
    logic byte_done;
    logic [7:0] status_word;
    logic cs_rise;
    logic cs_d_reg;

    assign pins = '{sck: sck, cs_n: cs_n, si: si, hold_n: hold_n, wp_n: wp_n};

    // Reset to idle pin levels: clock low, deselected, hold and protect released
    sefe_sync #(.WIDTH(5), .RST_VAL(5'h0b)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d_async(pins),
        .q_sync(pins_sync)
    );

    function automatic logic protected_addr(input logic [1:0] bp, input logic [AW-1:0] a);
        logic [1:0] quarter;
        quarter = a[AW-1:AW-2];
        case (bp)
            2'h0: protected_addr = 1'b0;
            2'h1: protected_addr = (quarter == 2'h3);
            2'h2: protected_addr = quarter[1];
            default: protected_addr = 1'b1;
        endcase
    endfunction

    assign selected = !pins_sync.cs_n;
    assign active = selected && pins_sync.hold_n;
    // Edges of sck are seen only while selected and not paused
    assign rise = active && pins_sync.sck && !sck_d_reg;
    assign fall = active && !pins_sync.sck && sck_d_reg;
    assign shift_next = {shift_reg[6:0], pins_sync.si};
    assign byte_done = rise && (bit_cnt_reg == 3'h7);
    assign cs_rise = pins_sync.cs_n && !cs_d_reg;
    assign status_word = {nv_reg[2], 3'h0, nv_reg[1:0], latch_reg, busy_reg};

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sck_d_reg <= 1'b0;
            cs_d_reg <= 1'b1;
        end else begin
            // Freeze the edge reference during pause so no edge is invented
            if (!selected || pins_sync.hold_n) begin
                sck_d_reg <= pins_sync.sck;
            end
            cs_d_reg <= pins_sync.cs_n;
        end
    end

    // Command, address and data shifting
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= SEFE_S_CMD;
            shift_reg <= 8'h00;
            bit_cnt_reg <= 3'h0;
            addr_bytes_reg <= 2'h0;
            addr_reg <= 16'h0000;
            write_pend_reg <= 1'b0;
            status_pend_reg <= 1'b0;
            latch_pend_set_reg <= 1'b0;
            latch_pend_clr_reg <= 1'b0;
            status_new_reg <= 3'h0;
            page_dirty_reg <= '0;
        end else if (!selected) begin
            state_reg <= SEFE_S_CMD;
            bit_cnt_reg <= 3'h0;
            addr_bytes_reg <= 2'h0;
            if (cs_rise) begin
                write_pend_reg <= 1'b0;
                status_pend_reg <= 1'b0;
                latch_pend_set_reg <= 1'b0;
                latch_pend_clr_reg <= 1'b0;
                // Page image is kept: the commit copies it at the end of the write cycle
            end
        end else if (rise) begin
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            // A clock after a completed byte makes any pending write invalid
            if (bit_cnt_reg == 3'h0) begin
                write_pend_reg <= 1'b0;
                status_pend_reg <= 1'b0;
                latch_pend_set_reg <= 1'b0;
                latch_pend_clr_reg <= 1'b0;
            end
            if (byte_done) begin
                case (state_reg)
                    SEFE_S_CMD: begin
                        if (busy_reg && shift_next != SEFE_CMD_READ_STATUS) begin
                            state_reg <= SEFE_S_IGNORE;
                        end else if (shift_next == SEFE_CMD_SET_LATCH) begin
                            latch_pend_set_reg <= 1'b1;
                            state_reg <= SEFE_S_IGNORE;
                        end else if (shift_next == SEFE_CMD_CLR_LATCH) begin
                            latch_pend_clr_reg <= 1'b1;
                            state_reg <= SEFE_S_IGNORE;
                        end else if (shift_next == SEFE_CMD_READ_STATUS) begin
                            state_reg <= SEFE_S_STAT_RD;
                        end else if (shift_next == SEFE_CMD_WRITE_STATUS) begin
                            state_reg <= latch_reg ? SEFE_S_STAT_WR : SEFE_S_IGNORE;
                        end else if (shift_next == SEFE_CMD_READ) begin
                            state_reg <= SEFE_S_ADDR;
                        end else if (shift_next == SEFE_CMD_WRITE) begin
                            // Fresh page image; no write frame is taken while busy
                            page_dirty_reg <= '0;
                            state_reg <= latch_reg ? SEFE_S_ADDR : SEFE_S_IGNORE;
                        end else begin
                            state_reg <= SEFE_S_IGNORE;
                        end
                        // Bit 1 marks a write, bit 0 the first address byte seen
                        if (shift_next == SEFE_CMD_WRITE) begin
                            addr_bytes_reg <= 2'h2;
                        end else begin
                            addr_bytes_reg <= 2'h0;
                        end
                    end
                    SEFE_S_ADDR: begin
                        addr_reg <= {addr_reg[7:0], shift_next};
                        // First byte only marks progress; the second picks the data phase
                        if (!addr_bytes_reg[0]) begin
                            addr_bytes_reg[0] <= 1'b1;
                        end else if (addr_bytes_reg[1]) begin
                            state_reg <= SEFE_S_WDATA;
                        end else begin
                            state_reg <= SEFE_S_RDATA;
                        end
                    end
                    SEFE_S_WDATA: begin
                        page_buf[addr_reg[PW-1:0]] <= shift_next;
                        page_dirty_reg[addr_reg[PW-1:0]] <= 1'b1;
                        addr_reg[PW-1:0] <= addr_reg[PW-1:0] + 1'b1;
                        write_pend_reg <= 1'b1;
                    end
                    SEFE_S_RDATA: begin
                        addr_reg[AW-1:0] <= addr_reg[AW-1:0] + 1'b1;
                    end
                    SEFE_S_STAT_WR: begin
                        status_new_reg <= {shift_next[SEFE_ST_PEN_BIT],
                            shift_next[SEFE_ST_BP1_BIT], shift_next[SEFE_ST_BP0_BIT]};
                        status_pend_reg <= 1'b1;
                        state_reg <= SEFE_S_IGNORE;
                    end
                    default: state_reg <= state_reg;
                endcase
            end
        end
    end

    // Serial output loads a byte at its first falling edge and shifts after
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_reg <= 8'h00;
            so_reg <= 1'b0;
        end else if (fall) begin
            if (bit_cnt_reg == 3'h0) begin
                if (state_reg == SEFE_S_STAT_RD) begin
                    so_reg <= status_word[7];
                    out_reg <= {status_word[6:0], 1'b0};
                end else if (state_reg == SEFE_S_RDATA) begin
                    so_reg <= mem[addr_reg[AW-1:0]][7];
                    out_reg <= {mem[addr_reg[AW-1:0]][6:0], 1'b0};
                end
            end else begin
                so_reg <= out_reg[7];
                out_reg <= {out_reg[6:0], 1'b0};
            end
        end
    end

    assign so_out = so_reg;
    assign so_oe = active && (state_reg == SEFE_S_STAT_RD || state_reg == SEFE_S_RDATA);

    // Latch, status and self-timed write commit on select rise
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            latch_reg <= 1'b0;
            nv_reg <= SEFE_NV_RESET;
            busy_reg <= 1'b0;
            busy_cnt_reg <= '0;
            commit_base_reg <= '0;
        end else begin
            // The page image lands in the array on the last cycle of the write
            if (busy_reg) begin
                if (busy_cnt_reg == CW'(WRITE_CYCLES - 1)) begin
                    busy_reg <= 1'b0;
                    for (int i = 0; i < PAGE_BYTES; i++) begin
                        if (page_dirty_reg[i]) begin
                            mem[{commit_base_reg[AW-1:PW], PW'(i)}] <= page_buf[i];
                        end
                    end
                end
                busy_cnt_reg <= busy_cnt_reg + 1'b1;
            end
            if (cs_rise) begin
                if (latch_pend_set_reg) begin
                    latch_reg <= 1'b1;
                end else if (latch_pend_clr_reg) begin
                    latch_reg <= 1'b0;
                end else if (status_pend_reg && latch_reg) begin
                    // A refused write leaves the latch set; a committed one clears it
                    if (!(nv_reg[2] && !pins_sync.wp_n)) begin
                        latch_reg <= 1'b0;
                        nv_reg <= status_new_reg;
                        busy_reg <= 1'b1;
                        busy_cnt_reg <= '0;
                    end
                end else if (write_pend_reg && latch_reg) begin
                    if (!protected_addr(nv_reg[1:0], addr_reg[AW-1:0])) begin
                        latch_reg <= 1'b0;
                        commit_base_reg <= addr_reg[AW-1:0];
                        busy_reg <= 1'b1;
                        busy_cnt_reg <= '0;
                    end
                end
            end
        end
    end

    assign write_busy_flag = busy_reg;
    assign write_latch_flag = latch_reg;
    assign status_out = status_word;
endmodule

// ### rtl/sefe_pkg.sv
// Purpose: Shared constants and types for the serial EEPROM front end
// Assumes: System clock of 10 MHz, serial pins sampled by that clock
// Notes: Write cycle time is held in microseconds and converted to cycles
package sefe_pkg;
    localparam int SEFE_CLK_HZ = 10000000;
    localparam int SEFE_WRITE_TIME_US = 5000;
    localparam int SEFE_WRITE_CYCLES = SEFE_WRITE_TIME_US * (SEFE_CLK_HZ / 1000000);
    localparam int SEFE_MEM_BYTES = 4096;
    localparam int SEFE_ADDR_W = 12;
    localparam int SEFE_PAGE_BYTES = 32;
    localparam logic [7:0] SEFE_CMD_SET_LATCH = 8'h06;
    localparam logic [7:0] SEFE_CMD_CLR_LATCH = 8'h04;
    localparam logic [7:0] SEFE_CMD_READ_STATUS = 8'h05;
    localparam logic [7:0] SEFE_CMD_WRITE_STATUS = 8'h01;
    localparam logic [7:0] SEFE_CMD_READ = 8'h03;
    localparam logic [7:0] SEFE_CMD_WRITE = 8'h02;
    localparam int SEFE_ST_BUSY_BIT = 0;
    localparam int SEFE_ST_LATCH_BIT = 1;
    localparam int SEFE_ST_BP0_BIT = 2;
    localparam int SEFE_ST_BP1_BIT = 3;
    localparam int SEFE_ST_PEN_BIT = 7;
    localparam logic [2:0] SEFE_NV_RESET = 3'h0;

    // Raw serial pins as seen after synchronisation
    typedef struct packed {
        logic sck;
        logic cs_n;
        logic si;
        logic hold_n;
        logic wp_n;
    } sefe_pins_t;

    typedef enum logic [2:0] {
        SEFE_S_CMD,
        SEFE_S_ADDR,
        SEFE_S_WDATA,
        SEFE_S_RDATA,
        SEFE_S_STAT_RD,
        SEFE_S_STAT_WR,
        SEFE_S_IGNORE
    } sefe_state_t;
endpackage

// ### rtl/sefe_sync.sv
// Purpose: Two-flop synchroniser for the serial pins
// Assumes: Pins are asynchronous to clk
// Notes: Idle pins reset to deselected, clock low, hold released
`timescale 1ns/1ps
module sefe_sync
    import sefe_pkg::*;
#(
    parameter int WIDTH = 5,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] d_async,
    output logic [WIDTH-1:0] q_sync
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] q_reg;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= RST_VAL;
            q_reg <= RST_VAL;
        end else begin
            meta_reg <= d_async;
            q_reg <= meta_reg;
        end
    end

    assign q_sync = q_reg;
endmodule

// ### tb/sefe_front_end_properties.sv
// Purpose: Port level checks on the serial EEPROM front end
// Assumes: Serial pins reach the logic through two sync flops
// Notes: Bound into every front end instance
`timescale 1ns/1ps
module sefe_front_end_properties
    import sefe_pkg::*;
#(
    parameter int WRITE_CYCLES = SEFE_WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic so_out,
    input wire logic so_oe,
    input wire logic write_busy_flag,
    input wire logic write_latch_flag,
    input wire logic [7:0] status_out
);
    logic [31:0] busy_cnt_reg;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_cnt_reg <= 32'h0;
        end else begin
            busy_cnt_reg <= write_busy_flag ? busy_cnt_reg + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_quiet_desel;
        cs_n && $past(cs_n) && $past(cs_n, 2) && $past(cs_n, 3) |-> !so_oe;
    endproperty
    a_quiet_desel: assert property (p_quiet_desel)
        else $error("output driven while deselected");
    property p_quiet_pause;
        !hold_n [*4] |-> !so_oe;
    endproperty
    a_quiet_pause: assert property (p_quiet_pause)
        else $error("output driven while paused");
    property p_frozen;
        !hold_n [*6] |=> $stable(so_out) && $stable(write_latch_flag);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("state moved while paused");
    property p_busy_start;
        $rose(write_busy_flag) |-> cs_n && $past(cs_n, 2);
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("write cycle began while selected");
    property p_busy_len;
        $fell(write_busy_flag) |-> busy_cnt_reg == WRITE_CYCLES;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("write cycle length wrong");
    property p_busy_latch;
        $rose(write_busy_flag) |-> $past(write_latch_flag);
    endproperty
    a_busy_latch: assert property (p_busy_latch)
        else $error("write began without latch");
    property p_latch_set;
        $rose(write_latch_flag) |-> cs_n && $past(cs_n);
    endproperty
    a_latch_set: assert property (p_latch_set)
        else $error("latch set before deselect");
    property p_status_map;
        status_out[SEFE_ST_BUSY_BIT] == write_busy_flag
            && status_out[SEFE_ST_LATCH_BIT] == write_latch_flag;
    endproperty
    a_status_map: assert property (p_status_map)
        else $error("status bits differ from flags");
    property p_so_change;
        $changed(so_out) && so_oe && $past(so_oe) |-> !$past(sck, 3);
    endproperty
    a_so_change: assert property (p_so_change)
        else $error("output moved outside falling edge");
    c_busy: cover property ($rose(write_busy_flag));
    c_latch: cover property ($rose(write_latch_flag));
    c_drive: cover property (so_oe && !hold_n);
endmodule
bind sefe_front_end sefe_front_end_properties #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
    .clk(clk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
    .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe), .write_busy_flag(write_busy_flag),
    .write_latch_flag(write_latch_flag), .status_out(status_out)
);

// ### tb/sefe_front_end_test.sv
// Purpose: Self-checking bench for the serial EEPROM front end
// Assumes: Write cycle shortened through WRITE_CYCLES
// Notes: Status protect cases run from a table, the rest by hand
`timescale 1ns/1ps
module sefe_front_end_test
    import sefe_pkg::*;
;
    localparam int WC = 400;
    typedef struct packed {
        logic mode;
        logic wp;
        logic set;
        logic [7:0] wr;
        logic [7:0] exp;
    } sefe_row_t;
    sefe_row_t rows [6];
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic sck, cs_n, si, hold_n, wp_n, so_out, so_oe, busy, latch;
    logic [7:0] status_out;
    logic [39:0] rx;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    always #50 clk = ~clk;
    sefe_host_model host (.clk(clk), .so_out(so_out), .so_oe(so_oe), .sck(sck), .cs_n(cs_n),
        .si(si), .hold_n(hold_n), .wp_n(wp_n));
    sefe_front_end #(.WRITE_CYCLES(WC)) dut (.clk(clk), .sys_rst(sys_rst), .sck(sck),
        .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe),
        .write_busy_flag(busy), .write_latch_flag(latch), .status_out(status_out));
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic mode, input logic [39:0] b, input int n, input int pz);
        logic [7:0] r;
        host.open_frame(mode);
        for (int k = 0; k < n; k++) begin
            host.xbyte(b[39-8*k -: 8], (k == 1) ? pz : -1, r);
            rx[39-8*k -: 8] = r;
        end
        host.close_frame();
    endtask
    task automatic wait_idle();
        host.tick(8);
        for (int k = 0; k < WC * 2 && busy !== 1'b0; k++) begin
            host.tick(1);
        end
    endtask
    initial begin
        rows[0] = '{1'b0, 1'b0, 1'b0, 8'h8c, 8'h00};
        rows[1] = '{1'b1, 1'b0, 1'b1, 8'h84, 8'h84};
        rows[2] = '{1'b0, 1'b0, 1'b1, 8'h00, 8'h86};
        rows[3] = '{1'b1, 1'b1, 1'b1, 8'h08, 8'h08};
        rows[4] = '{1'b0, 1'b1, 1'b0, 8'h00, 8'h08};
        rows[5] = '{1'b1, 1'b1, 1'b1, 8'h73, 8'h00};
        host.tick(3);
        check({so_oe, status_out[6:0]}, 8'h00);
        sys_rst = 1'b0;
        host.tick(3);
        foreach (rows[r]) begin
            host.set_wp(rows[r].wp);
            if (rows[r].set) begin
                xfer(rows[r].mode, {SEFE_CMD_SET_LATCH, 32'h0}, 1, -1);
            end
            xfer(rows[r].mode, {SEFE_CMD_WRITE_STATUS, rows[r].wr, 24'h0}, 2, -1);
            wait_idle();
            xfer(rows[r].mode, {SEFE_CMD_READ_STATUS, 32'h0}, 2, -1);
            check(rx[31:24], rows[r].exp);
            check(status_out, rows[r].exp);
        end
        host.xbyte(SEFE_CMD_SET_LATCH, -1, rx[7:0]);
        host.open_frame(1'b0);
        host.close_frame();
        check({7'h0, latch}, 8'h00);
        xfer(1'b0, {SEFE_CMD_SET_LATCH, 32'h0}, 1, -1);
        check({7'h0, latch}, 8'h01);
        xfer(1'b1, {SEFE_CMD_CLR_LATCH, 32'h0}, 1, -1);
        check({7'h0, latch}, 8'h00);
        xfer(1'b0, {SEFE_CMD_SET_LATCH, 32'h0}, 1, -1);
        xfer(1'b0, {SEFE_CMD_WRITE, 8'hfa, 8'hb5, 8'h5a, 8'hc3}, 5, 3);
        xfer(1'b1, {SEFE_CMD_READ_STATUS, 32'h0}, 2, -1);
        check({7'h0, rx[24]}, 8'h01);
        wait_idle();
        check({7'h0, latch}, 8'h00);
        xfer(1'b1, {SEFE_CMD_READ, 8'h0a, 8'hb5, 16'h0}, 5, 5);
        check(rx[15:8], 8'h5a);
        check(rx[7:0], 8'hc3);
        xfer(1'b0, {SEFE_CMD_SET_LATCH, SEFE_CMD_WRITE, 8'h0a, 8'hb5, 8'h77}, 5, -1);
        check({7'h0, busy}, 8'h00);
        xfer(1'b0, {SEFE_CMD_READ, 8'h0a, 8'hb5, 16'h0}, 4, -1);
        check(rx[15:8], 8'h5a);
        xfer(1'b1, {SEFE_CMD_SET_LATCH, 32'h0}, 1, -1);
        xfer(1'b1, {SEFE_CMD_WRITE_STATUS, 8'h0c, 24'h0}, 2, -1);
        wait_idle();
        check(status_out, 8'h0c);
        xfer(1'b1, {SEFE_CMD_SET_LATCH, 32'h0}, 1, -1);
        xfer(1'b1, {SEFE_CMD_WRITE, 8'h0a, 8'hb5, 8'h11, 8'h00}, 4, -1);
        check({7'h0, busy}, 8'h00);
        xfer(1'b1, {SEFE_CMD_READ, 8'h0a, 8'hb5, 16'h0}, 4, -1);
        check(rx[15:8], 8'h5a);
        sys_rst = 1'b1;
        host.tick(2);
        check({latch, status_out[6:0]}, 8'h00);
        sys_rst = 1'b0;
        host.tick(3);
        wrap_up();
    end
endmodule

// ### tb/sefe_host_model.sv
// Purpose: Behavioural SPI host driving the front end pins
// Assumes: Half serial period of four clk cycles, 800 ns period
// Notes: Released data line reads as the inverse of its last value
`timescale 1ns/1ps
module sefe_host_model (
    input wire logic clk,
    input wire logic so_out,
    input wire logic so_oe,
    output logic sck,
    output logic cs_n,
    output logic si,
    output logic hold_n,
    output logic wp_n
);
    logic so_last = 1'b0;
    logic mode_r = 1'b0;
    wire logic so_line = so_oe ? so_out : ~so_last;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
        wp_n = 1'b1;
    end
    always @(posedge clk) begin
        if (so_oe) begin
            so_last <= so_out;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic set_wp(input logic level);
        wp_n = level;
    endtask
    task automatic open_frame(input logic mode);
        mode_r = mode;
        sck = mode;
        tick(4);
        cs_n = 1'b0;
        tick(4);
    endtask
    task automatic xbyte(input logic [7:0] tx, input int pause_at, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck = 1'b0;
            si = tx[i];
            tick(4);
            if (i == pause_at) begin
                hold_n = 1'b0;
                repeat (3) begin
                    sck = ~sck;
                    si = ~si;
                    tick(2);
                end
                sck = 1'b0;
                si = tx[i];
                tick(2);
                hold_n = 1'b1;
                tick(4);
            end
            sck = 1'b1;
            tick(4);
            rx[i] = so_line;
        end
    endtask
    task automatic close_frame();
        if (!mode_r) begin
            sck = 1'b0;
            tick(4);
        end
        cs_n = 1'b1;
        si = ~si;
        tick(8);
    endtask
endmodule
